// >>> hdl/rswcm_pkg.sv
// Constants, types and register map of the reset source and watchdog block
package rswcm_pkg;
    // APB address width and register word indices (byte address = 4 * index)
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_STATUS = 8'h30;
    localparam logic [7:0] IDX_OPTIONS = 8'h39;
    localparam logic [7:0] IDX_SERVICE = 8'h3a;
    localparam logic [7:0] IDX_TEST = 8'h3e;
    localparam logic [7:0] IDX_CONFIG = 8'h3f;

    // Field positions
    localparam int OPT_IRQ_EDGE_SELECT = 5;
    localparam int OPT_DLY = 4;
    localparam int OPT_CME = 3;
    localparam int OPT_CR = 0;
    localparam int CFG_WATCHDOG_DISABLE_BIT = 2;
    localparam int TST_DISABLE_RESETS_BIT = 0;
    localparam int STS_CAUSE = 0;
    localparam int STS_ACTIVE = 2;

    // Reset values and service keys
    localparam logic [7:0] OPT_RESET = 8'h10;
    localparam logic [7:0] SVC_ARM = 8'h55;
    localparam logic [7:0] SVC_CLEAR = 8'haa;

    // Timing in E-clock cycles (E clock is clk)
    localparam logic [6:0] PROT_WINDOW = 7'h40;
    localparam logic [2:0] PIN_DRIVE_CYC = 3'h4;
    localparam logic [2:0] PIN_SETTLE_CYC = 3'h2;
    localparam logic [2:0] SYNC_STAGES = 3'h2;

    // Reset cause codes
    typedef enum logic [1:0] {
        CAUSE_POR = 2'b00,
        CAUSE_EXT = 2'b01,
        CAUSE_CMF = 2'b10,
        CAUSE_WDT = 2'b11
    } rswcm_cause_e;

    // Reset pin sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DRIVE = 3'b001,
        ST_SETTLE = 3'b010,
        ST_SAMPLE = 3'b011,
        ST_HOLD = 3'b100
    } rswcm_state_e;

    // Configuration seen by the rest of the chip
    typedef struct packed {
        logic irq_edge_select;
        logic stop_exit_delay_enable;
        logic clock_monitor_enable;
        logic [1:0] watchdog_rate_select;
        logic watchdog_disable_bit;
        logic disable_resets_bit;
    } rswcm_cfg_s;
endpackage

// >>> hdl/rswcm_top.sv
// Reset source sequencer, watchdog, clock monitor gate and option registers
//
// Behaviour
// - Any reset except power-on drives pin low four cycles
// - Sample pin two cycles later; low means external
// - Normal modes: watchdog runs from reset unless disabled
// - Special modes: disable-resets bit inhibits watchdog resets
// - Watchdog period E/2^15 times 1, 4, 16, 64
// - Reset clears rate select to shortest period
// - Protected bits write once in first 64 cycles in normal modes
// - Write 55 then AA clears watchdog
// - Watchdog timeout starts system reset sequence
// - Enabled clock monitor resets on missing clock
// - Monitor flags below 10 kHz, never above 200 kHz
// - Watchdog stops while clocks are stopped
// - Stop with clock monitor enabled causes reset
// - Monitor enable always writable, cleared by reset
// - IRQ select: 0 low level, 1 falling edge
// - Reset sets stop-exit delay bit
// - Disable bit resets by mode, write-once in normal
// - Disable bit set means no watchdog reset
// - Reset cause selects the restart vector
`timescale 1ns/10ps
module rswcm_top #(
    parameter int WDT_PRE_BITS = 15,
    parameter int WDT_SCALE_BITS = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rswcm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic special_mode,
    input wire logic stop_mode,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic cm_rc_timeout,
    output logic cm_detector_enable,
    output logic clock_fail_reset,
    input wire logic irq_pin_n,
    input wire logic irq_ack,
    output logic irq_request,
    output logic system_reset,
    output logic [1:0] reset_cause,
    output rswcm_pkg::rswcm_cfg_s cfg
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (WDT_PRE_BITS < 1 || WDT_PRE_BITS > 24) begin : g_bad_pre
        $error("WDT_PRE_BITS out of range");
    end
    if (WDT_SCALE_BITS != 6) begin : g_bad_scale
        $error("WDT_SCALE_BITS must be 6");
    end

    // Word index decode of an APB address
    function automatic logic hit(input logic [rswcm_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        hit = (a[rswcm_pkg::ADDR_W-1:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
    endfunction

    // Terminal count of the scaler for each rate select
    function automatic logic [5:0] scale_max(input logic [1:0] rs);
        case (rs)
            2'h0: scale_max = 6'h00;
            2'h1: scale_max = 6'h03;
            2'h2: scale_max = 6'h0f;
            default: scale_max = 6'h3f;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [1:0] pin_sync_reg;
    logic [1:0] rc_sync_reg;
    logic [1:0] irq_sync_reg;
    logic irq_prev_reg;

    // Pins and the analog detector are asynchronous to clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync_reg <= 2'h3;
            rc_sync_reg <= 2'h0;
            irq_sync_reg <= 2'h3;
            irq_prev_reg <= 1'b1;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], reset_pin_in};
            rc_sync_reg <= {rc_sync_reg[0], cm_rc_timeout};
            irq_sync_reg <= {irq_sync_reg[0], irq_pin_n};
            irq_prev_reg <= irq_sync_reg[1];
        end
    end

    logic pin_high;
    logic rc_fail;
    assign pin_high = pin_sync_reg[1];
    assign rc_fail = rc_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in setup

    logic wr_acc;
    logic rd_setup;
    logic mapped;
    logic [31:0] prdata_reg;
    logic [7:0] rd_byte;

    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped = hit(paddr, rswcm_pkg::IDX_STATUS) || hit(paddr, rswcm_pkg::IDX_OPTIONS)
        || hit(paddr, rswcm_pkg::IDX_SERVICE) || hit(paddr, rswcm_pkg::IDX_TEST)
        || hit(paddr, rswcm_pkg::IDX_CONFIG);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Initialisation after power-on release or a sequenced system reset

    logic init_done_reg;
    logic init_pulse;
    logic sys_rst;
    logic [6:0] win_cnt_reg;
    logic win_open;

    assign init_pulse = !init_done_reg || sys_rst;
    assign win_open = win_cnt_reg < rswcm_pkg::PROT_WINDOW;

    // Mode straps are caught on the first edge after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_done_reg <= 1'b0;
        end else begin
            init_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt_reg <= 7'h00;
        end else if (init_pulse) begin
            win_cnt_reg <= 7'h00;
        end else if (win_open) begin
            win_cnt_reg <= win_cnt_reg + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Option, configuration and test registers

    logic wr_opt;
    logic wr_cfg;
    logic wr_tst;
    logic opt_once_reg;
    logic cfg_once_reg;
    logic opt_prot_ok;
    logic cfg_prot_ok;

    assign wr_opt = wr_acc && hit(paddr, rswcm_pkg::IDX_OPTIONS);
    assign wr_cfg = wr_acc && hit(paddr, rswcm_pkg::IDX_CONFIG);
    assign wr_tst = wr_acc && hit(paddr, rswcm_pkg::IDX_TEST);
    // one write inside the window in normal modes, any time in special
    assign opt_prot_ok = special_mode || (win_open && !opt_once_reg);
    // disable bit write-once in normal modes
    assign cfg_prot_ok = special_mode || !cfg_once_reg;

    // Write-once bookkeeping, restarted by every reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_once_reg <= 1'b0;
            cfg_once_reg <= 1'b0;
        end else if (init_pulse) begin
            opt_once_reg <= 1'b0;
            cfg_once_reg <= 1'b0;
        end else begin
            if (wr_opt && opt_prot_ok) begin
                opt_once_reg <= 1'b1;
            end
            if (wr_cfg && cfg_prot_ok) begin
                cfg_once_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg.irq_edge_select <= rswcm_pkg::OPT_RESET[rswcm_pkg::OPT_IRQ_EDGE_SELECT];
            cfg.stop_exit_delay_enable <= rswcm_pkg::OPT_RESET[rswcm_pkg::OPT_DLY];
            cfg.clock_monitor_enable <= rswcm_pkg::OPT_RESET[rswcm_pkg::OPT_CME];
            cfg.watchdog_rate_select <= rswcm_pkg::OPT_RESET[rswcm_pkg::OPT_CR +: 2];
            cfg.watchdog_disable_bit <= 1'b1;
            cfg.disable_resets_bit <= 1'b1;
        end else if (init_pulse) begin
            cfg.irq_edge_select <= rswcm_pkg::OPT_RESET[rswcm_pkg::OPT_IRQ_EDGE_SELECT];
            cfg.stop_exit_delay_enable <= rswcm_pkg::OPT_RESET[rswcm_pkg::OPT_DLY];
            cfg.clock_monitor_enable <= rswcm_pkg::OPT_RESET[rswcm_pkg::OPT_CME];
            cfg.watchdog_rate_select <= rswcm_pkg::OPT_RESET[rswcm_pkg::OPT_CR +: 2];
            cfg.watchdog_disable_bit <= special_mode;
            cfg.disable_resets_bit <= special_mode;
        end else if (wr_opt) begin
            // no protection on the monitor enable
            cfg.clock_monitor_enable <= pwdata[rswcm_pkg::OPT_CME];
            if (opt_prot_ok) begin
                cfg.irq_edge_select <= pwdata[rswcm_pkg::OPT_IRQ_EDGE_SELECT];
                cfg.stop_exit_delay_enable <= pwdata[rswcm_pkg::OPT_DLY];
                cfg.watchdog_rate_select <= pwdata[rswcm_pkg::OPT_CR +: 2];
            end
        end else if (wr_cfg && cfg_prot_ok) begin
            cfg.watchdog_disable_bit <= pwdata[rswcm_pkg::CFG_WATCHDOG_DISABLE_BIT];
        end else if (wr_tst && special_mode) begin
            cfg.disable_resets_bit <= pwdata[rswcm_pkg::TST_DISABLE_RESETS_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog service sequence and counter

    logic wr_svc;
    logic armed_reg;
    logic wd_clear;
    logic wd_enable;
    logic wd_timeout;
    logic [WDT_PRE_BITS-1:0] pre_cnt_reg;
    logic [WDT_SCALE_BITS-1:0] scale_cnt_reg;

    assign wr_svc = wr_acc && hit(paddr, rswcm_pkg::IDX_SERVICE);
    // clearing only after an arming write
    assign wd_clear = wr_svc && armed_reg && (pwdata[7:0] == rswcm_pkg::SVC_CLEAR);

    assign wd_enable = init_done_reg && !cfg.watchdog_disable_bit
        && !(special_mode && cfg.disable_resets_bit);

    // period is 2^15 cycles times the selected factor
    assign wd_timeout = wd_enable && !stop_mode && (&pre_cnt_reg)
        && (scale_cnt_reg == scale_max(cfg.watchdog_rate_select));

    // any value other than the arming key disarms
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
        end else if (init_pulse) begin
            armed_reg <= 1'b0;
        end else if (wr_svc) begin
            armed_reg <= (pwdata[7:0] == rswcm_pkg::SVC_ARM);
        end
    end

    // counting halts while the clocks are stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_reg <= '0;
            scale_cnt_reg <= '0;
        end else if (init_pulse || wd_clear || !wd_enable || wd_timeout) begin
            pre_cnt_reg <= '0;
            scale_cnt_reg <= '0;
        end else if (!stop_mode) begin
            pre_cnt_reg <= pre_cnt_reg + 1'b1;
            if (&pre_cnt_reg) begin
                scale_cnt_reg <= scale_cnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock monitor gate

    logic cm_trip;

    // the RC detector owns the frequency thresholds
    assign cm_detector_enable = cfg.clock_monitor_enable;
    // path that works with no clock running
    assign clock_fail_reset = cfg.clock_monitor_enable && cm_rc_timeout;
    // stop with the monitor enabled is a clock failure
    assign cm_trip = cfg.clock_monitor_enable && (rc_fail || stop_mode);

    ////////////////////////////////////////////////////////////////////////
    // Reset pin sequencer

    rswcm_pkg::rswcm_state_e state_reg;
    rswcm_pkg::rswcm_cause_e pend_reg;
    rswcm_pkg::rswcm_cause_e cause_reg;
    logic [2:0] cyc_reg;
    logic [2:0] settle_len;

    // Pin level reaches us two flops late
    assign settle_len = rswcm_pkg::PIN_SETTLE_CYC + rswcm_pkg::SYNC_STAGES;
    assign sys_rst = (state_reg == rswcm_pkg::ST_HOLD) && pin_high;
    assign system_reset = sys_rst;
    assign reset_cause = cause_reg;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = (state_reg == rswcm_pkg::ST_DRIVE);

    // detect, drive four cycles, settle, sample, wait high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= rswcm_pkg::ST_IDLE;
            pend_reg <= rswcm_pkg::CAUSE_EXT;
            cyc_reg <= 3'h0;
        end else begin
            case (state_reg)
                rswcm_pkg::ST_IDLE: begin
                    cyc_reg <= 3'h0;
                    // Monitor failure outranks watchdog timeout
                    if (cm_trip) begin
                        pend_reg <= rswcm_pkg::CAUSE_CMF;
                        state_reg <= rswcm_pkg::ST_DRIVE;
                    end else if (wd_timeout) begin
                        pend_reg <= rswcm_pkg::CAUSE_WDT;
                        state_reg <= rswcm_pkg::ST_DRIVE;
                    end else if (!pin_high && init_done_reg) begin
                        pend_reg <= rswcm_pkg::CAUSE_EXT;
                        state_reg <= rswcm_pkg::ST_DRIVE;
                    end
                end
                rswcm_pkg::ST_DRIVE: begin
                    if (cyc_reg == rswcm_pkg::PIN_DRIVE_CYC - 3'h1) begin
                        cyc_reg <= 3'h0;
                        state_reg <= rswcm_pkg::ST_SETTLE;
                    end else begin
                        cyc_reg <= cyc_reg + 3'h1;
                    end
                end
                rswcm_pkg::ST_SETTLE: begin
                    if (cyc_reg == settle_len - 3'h2) begin
                        cyc_reg <= 3'h0;
                        state_reg <= rswcm_pkg::ST_SAMPLE;
                    end else begin
                        cyc_reg <= cyc_reg + 3'h1;
                    end
                end
                rswcm_pkg::ST_SAMPLE: begin
                    state_reg <= rswcm_pkg::ST_HOLD;
                end
                rswcm_pkg::ST_HOLD: begin
                    if (pin_high) begin
                        state_reg <= rswcm_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= rswcm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // low at sample means external, else the internal cause
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_reg <= rswcm_pkg::CAUSE_POR;
        end else if (state_reg == rswcm_pkg::ST_SAMPLE) begin
            cause_reg <= pin_high ? pend_reg : rswcm_pkg::CAUSE_EXT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // IRQ recognition

    logic irq_req_reg;
    logic irq_fall;

    assign irq_fall = irq_prev_reg && !irq_sync_reg[1];
    assign irq_request = irq_req_reg;

    // level follows the pin, edge is latched until acknowledged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req_reg <= 1'b0;
        end else if (!cfg.irq_edge_select) begin
            irq_req_reg <= !irq_sync_reg[1];
        end else if (irq_fall) begin
            // A new edge wins over a same-cycle acknowledge
            irq_req_reg <= 1'b1;
        end else if (irq_ack) begin
            irq_req_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        rd_byte = 8'h00;
        if (hit(paddr, rswcm_pkg::IDX_OPTIONS)) begin
            rd_byte[rswcm_pkg::OPT_IRQ_EDGE_SELECT] = cfg.irq_edge_select;
            rd_byte[rswcm_pkg::OPT_DLY] = cfg.stop_exit_delay_enable;
            rd_byte[rswcm_pkg::OPT_CME] = cfg.clock_monitor_enable;
            rd_byte[rswcm_pkg::OPT_CR +: 2] = cfg.watchdog_rate_select;
        end else if (hit(paddr, rswcm_pkg::IDX_CONFIG)) begin
            rd_byte[rswcm_pkg::CFG_WATCHDOG_DISABLE_BIT] = cfg.watchdog_disable_bit;
        end else if (hit(paddr, rswcm_pkg::IDX_TEST)) begin
            rd_byte[rswcm_pkg::TST_DISABLE_RESETS_BIT] = cfg.disable_resets_bit;
        end else if (hit(paddr, rswcm_pkg::IDX_STATUS)) begin
            rd_byte[rswcm_pkg::STS_CAUSE +: 2] = cause_reg;
            rd_byte[rswcm_pkg::STS_ACTIVE] = wd_enable;
        end
    end

    // Service register is write-only and reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_reg <= {24'h00_0000, rd_byte};
        end
    end

endmodule

// >>> verif/rswcm_pin_model.sv
// Reset pin circuit beside the block: pull-up plus an external reset switch
`timescale 1ns/10ps
module rswcm_pin_model (
    input wire logic dev_oe,
    input wire logic dev_out,
    input wire logic ext_low,
    output logic pin_level
);
    // wired-low pin: the pull-up wins once nobody pulls
    assign pin_level = !((dev_oe && !dev_out) || ext_low);
endmodule

// >>> verif/rswcm_chk_sva.sv
// Concurrent checks on the ports of the reset source and watchdog block
`timescale 1ns/10ps
module rswcm_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [rswcm_pkg::ADDR_W-1:0] paddr,
    input wire logic pslverr,
    input wire logic special_mode,
    input wire logic reset_pin_oe,
    input wire logic cm_rc_timeout,
    input wire logic cm_detector_enable,
    input wire logic clock_fail_reset,
    input wire logic irq_pin_n,
    input wire logic irq_request,
    input wire logic system_reset,
    input wire rswcm_pkg::rswcm_cfg_s cfg
);
    logic [6:0] win_cnt;
    logic mapped;
    // Cycles since the last reset; saturates so it never wraps into the window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            win_cnt <= 7'h00;
        else if (system_reset)
            win_cnt <= 7'h00;
        else if (win_cnt != 7'h7f)
            win_cnt <= win_cnt + 7'h01;
    end
    // Aligned word addresses that hold a register
    assign mapped = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 &&
        (paddr[9:2] inside {rswcm_pkg::IDX_STATUS, rswcm_pkg::IDX_OPTIONS,
        rswcm_pkg::IDX_SERVICE, rswcm_pkg::IDX_TEST, rswcm_pkg::IDX_CONFIG});
    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pin_drive_four: assert property ($rose(reset_pin_oe) |->
        reset_pin_oe[*4] ##1 !reset_pin_oe) else $error("pin drive not four cycles");
    a_sample_gap: assert property ($fell(reset_pin_oe) |->
        !system_reset[*4]) else $error("sequence ended before the sample");
    a_unmapped_err: assert property (psel && penable && !mapped |->
        pslverr) else $error("unmapped access without error");
    a_fail_comb: assert property (clock_fail_reset ==
        (cm_detector_enable && cm_rc_timeout)) else $error("monitor trip wrong");
    a_rate_locked: assert property (!special_mode && win_cnt > 7'h46 &&
        !system_reset |=> $stable(cfg.watchdog_rate_select)) else $error("rate changed late");
    a_watchdog_disable_bit_locked: assert property (!special_mode && win_cnt > 7'h46 &&
        !system_reset |=> $stable(cfg.watchdog_disable_bit)) else $error("disable changed late");
    a_reinit_values: assert property (system_reset |=>
        cfg.watchdog_rate_select == 2'h0 && cfg.stop_exit_delay_enable &&
        !cfg.clock_monitor_enable) else $error("options not reinitialised");
    a_irq_level: assert property ((!cfg.irq_edge_select && !irq_pin_n)[*5] |->
        irq_request) else $error("level interrupt not raised");
    c_pin_seq: cover property ($rose(reset_pin_oe));
    c_mon_trip: cover property (clock_fail_reset);
    c_bus_err: cover property (psel && penable && pslverr);
endmodule
bind rswcm_top rswcm_chk chk_u (.clk, .rst_n, .psel, .penable, .paddr, .pslverr,
    .special_mode, .reset_pin_oe, .cm_rc_timeout, .cm_detector_enable,
    .clock_fail_reset, .irq_pin_n, .irq_request, .system_reset, .cfg);

// >>> verif/rswcm_top_tb_top.sv
// Self-checking bench of the reset source and watchdog block
`timescale 1ns/10ps
module rswcm_top_tb_top;
    localparam int PRE = 6;
    localparam int TO0 = 2 ** PRE;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic special_mode = 0, stop_mode = 0, cm_rc_timeout = 0;
    logic irq_pin_n = 1, irq_ack = 0, ext_low = 0, saw_oe = 0, last_err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, reset_pin_in, reset_pin_out, reset_pin_oe;
    logic cm_detector_enable, clock_fail_reset, irq_request, system_reset;
    logic [1:0] reset_cause;
    rswcm_pkg::rswcm_cfg_s cfg;
    int errors = 0, n_compared = 0, cyc = 0, t0 = 0;
    // Clock, cycle count and a sticky record of any pin drive
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(negedge clk) if (reset_pin_oe === 1'b1) saw_oe <= 1'b1;
    rswcm_top #(.WDT_PRE_BITS(PRE)) dut_u (.clk, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .special_mode, .stop_mode,
        .reset_pin_in, .reset_pin_out, .reset_pin_oe, .cm_rc_timeout,
        .cm_detector_enable, .clock_fail_reset, .irq_pin_n, .irq_ack, .irq_request,
        .system_reset, .reset_cause, .cfg);
    rswcm_pin_model pin_u (.dev_oe(reset_pin_oe), .dev_out(reset_pin_out),
        .ext_low(ext_low), .pin_level(reset_pin_in));
    ////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // One APB transfer; the request stands until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            end_sim();
        end
        rdv = prdata;
        last_err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Bounded wait for the pin drive (sr=0) or the end pulse (sr=1)
    task wait_hi(input logic sr, input int b);
        int i;
        for (i = 0; i < b; i++) begin
            @(negedge clk);
            if ((sr ? system_reset : reset_pin_oe) === 1'b1) break;
        end
        if (i == b) begin
            errors++;
            end_sim();
        end
    endtask
    // Rest of a pin sequence once the drive is seen
    task seq(input logic [1:0] cause);
        int n;
        n = 0;
        while (reset_pin_oe === 1'b1 && n < 9) begin
            n++;
            @(negedge clk);
        end
        check(n, 4, "pin drive cycles"); // drive length
        wait_hi(1, 40);
        t0 = cyc;
        check(reset_cause, cause, "reset cause"); // cause code
    endtask
    task period(input int to);
        wait_hi(0, to + 20);
        check((cyc - t0 >= to) && (cyc - t0 <= to + 6), 1, "period"); // timeout
    endtask
    task do_reset(input logic special);
        special_mode <= special;
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        t0 = cyc;
    endtask
    ////////////////////////////////////////
    task t_reset_values;
        apb(0, 12'h0e4, 0);
        check(rdv, 32'h10, "options reset"); // reset value
        apb(0, 12'h0fc, 0);
        check(rdv, 32'h0, "config reset"); // normal mode
        apb(0, 12'h004, 0);
        check({rdv[30:0], last_err}, 32'h1, "unmapped read"); // refused
        irq_pin_n <= 0;
        repeat (6) @(negedge clk);
        check(irq_request, 1, "level irq"); // low level
        irq_pin_n <= 1;
        $display("reset values done");
    endtask
    task t_protect;
        apb(1, 12'h0e4, 8'hff);
        apb(1, 12'h0e4, 8'h00);
        apb(0, 12'h0e4, 0);
        check(rdv, 32'h33, "options once"); // write once
        check(cfg, 32'h6c, "cfg outputs"); // carried out
        irq_pin_n <= 0;
        repeat (4) @(posedge clk);
        irq_pin_n <= 1;
        repeat (4) @(posedge clk);
        check(irq_request, 1, "edge irq"); // falling edge
        irq_ack <= 1;
        @(posedge clk);
        irq_ack <= 0;
        @(negedge clk);
        check(irq_request, 0, "irq ack"); // ack clears
        apb(1, 12'h0fc, 8'h00);
        apb(1, 12'h0fc, 8'h04);
        apb(0, 12'h0fc, 0);
        check(rdv, 32'h0, "config once"); // write once
        period(TO0 * 64);
        seq(rswcm_pkg::CAUSE_WDT);
        $display("protection done");
    endtask
    task t_service;
        apb(0, 12'h0e4, 0);
        check(rdv, 32'h10, "rate after reset"); // shortest rate
        period(TO0);
        seq(rswcm_pkg::CAUSE_WDT);
        saw_oe <= 0;
        repeat (5) begin
            repeat (30) @(posedge clk);
            apb(1, 12'h0e8, 8'h55);
            apb(1, 12'h0e8, 8'haa);
        end
        t0 = cyc;
        check(saw_oe, 0, "serviced"); // no timeout
        apb(1, 12'h0e8, 8'h55);
        apb(1, 12'h0e8, 8'h12);
        apb(1, 12'h0e8, 8'haa);
        period(TO0);
        seq(rswcm_pkg::CAUSE_WDT);
        $display("service done");
    endtask
    task t_external;
        @(posedge clk);
        ext_low <= 1;
        fork
            begin
                repeat (16) @(posedge clk);
                ext_low <= 0;
            end
        join_none
        wait_hi(0, 10);
        seq(rswcm_pkg::CAUSE_EXT);
        $display("external done");
    endtask
    task t_clock_monitor;
        apb(1, 12'h0e4, 8'h18);
        cm_rc_timeout <= 1;
        @(negedge clk);
        check(clock_fail_reset, 1, "monitor trip"); // no clock needed
        wait_hi(0, 10);
        cm_rc_timeout <= 0;
        seq(rswcm_pkg::CAUSE_CMF);
        saw_oe <= 0;
        apb(1, 12'h0e4, 8'h10);
        stop_mode <= 1;
        repeat (150) @(posedge clk);
        stop_mode <= 0;
        check(saw_oe, 0, "stop frozen"); // frozen count
        apb(1, 12'h0e4, 8'h08);
        stop_mode <= 1;
        wait_hi(0, 10);
        stop_mode <= 0;
        seq(rswcm_pkg::CAUSE_CMF); // stop with monitor
        $display("clock monitor done");
    endtask
    task t_special;
        do_reset(1);
        apb(0, 12'h0fc, 0);
        check(rdv, 32'h4, "special config"); // special reset
        apb(0, 12'h0f8, 0);
        check(rdv, 32'h1, "test reg"); // inhibit at reset
        apb(1, 12'h0e4, 8'h33);
        apb(1, 12'h0e4, 8'h10);
        apb(0, 12'h0e4, 0);
        check(rdv, 32'h10, "special rewrite"); // second write kept
        saw_oe <= 0;
        apb(1, 12'h0f8, 8'h00);
        repeat (200) @(posedge clk);
        check(saw_oe, 0, "disabled quiet"); // no reset
        apb(1, 12'h0fc, 8'h00);
        wait_hi(0, TO0 + 20);
        seq(rswcm_pkg::CAUSE_WDT); // enabled again
        $display("special done");
    endtask
    // Main sequence
    initial begin
        do_reset(0);
        t_reset_values();
        t_protect();
        t_service();
        t_external();
        t_clock_monitor();
        t_special();
        end_sim();
    end
endmodule
